// *** i2cmem_pkg.sv ***
// Constants, state codes and field layouts for the serial memory access slave.
// Assumes a core clock of 100 MHz and a processor-side clock in its own domain.
// Function
// - Idle bus: both lines released high
// - SDA fall with SCL high starts transfer
// - SDA rise with SCL high ends transfer
// - Data held steady while SCL high
// - Start only on idle bus; one bit/pulse
// - Serial clock up to 400 kHz works
// - Unlimited bytes; each byte gets ack slot
// - Receiver acknowledges every received byte; master withholds ack on last read byte
// - Acknowledger holds SDA low over ack pulse
// - No ack seen: transmitter releases SDA
// - First byte is address; match only responds
// - Slave only; SCL input, SDA open drain
// - Fixed upper address bits, pin sets LSB
// - Address pin feeds test serial input
// - Words of 2 or 3 bytes by address
// - Read starts with write of memory address
// - Read streams 2 or 3 byte groups
// - Not-acknowledge ends read, bus released
// - Transfers only on host transfer instruction
package i2cmem_pkg;

  // ============================================================
  // Addressing
  localparam logic [5:0]  SLV_ADDR_HI   = 6'h0E;   // Fixed upper six address bits
  localparam int          WIDE_SEL_BIT  = 11;      // Clear selects the wide memory
  localparam logic [1:0]  BYTES_WIDE    = 2'h3;    // Bytes per wide word
  localparam logic [1:0]  BYTES_NARROW  = 2'h2;    // Bytes per narrow word

  // ============================================================
  // Reset values
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [23:0] WORD_RST      = 24'h000000;
  localparam logic [2:0]  BITCNT_RST    = 3'h0;
  localparam logic [2:0]  BITCNT_LAST   = 3'h7;    // Index of the eighth bit

  // ============================================================
  // Byte position inside a transaction
  localparam logic [1:0]  IDX_DEV       = 2'h0;    // Device address byte
  localparam logic [1:0]  IDX_AHI       = 2'h1;    // Memory address high byte
  localparam logic [1:0]  IDX_ALO       = 2'h2;    // Memory address low byte
  localparam logic [1:0]  IDX_DATA      = 2'h3;    // Data bytes

  // ============================================================
  // Serial engine states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,   // Bus free, lines released
    ST_RX     = 6'h02,   // Shifting a byte in
    ST_ACK    = 6'h04,   // Driving acknowledge low
    ST_TX     = 6'h08,   // Shifting a byte out
    ST_MACK   = 6'h10,   // Sampling master acknowledge
    ST_IGNORE = 6'h20    // Not addressed or read ended
  } i2cmem_state_t;

endpackage : i2cmem_pkg

// *** i2cmem_slave.sv ***
// Serial memory access slave: two-wire slave engine on the core clock and a
// processor-side transfer port on its own clock, joined by a toggle handshake.
// Assumes open-drain pad logic outside and one host transfer pulse per word.
`timescale 1ns/1ns
module i2cmem_slave (
  input  wire logic        clk,                       // Core clock, 100 MHz
  input  wire logic        arst_n,                    // Async reset, active low
  input  wire logic        scl_i,                     // Serial clock pin level
  input  wire logic        sda_i,                     // Serial data pin level
  output logic             sda_o,                     // Serial data drive value
  output logic             sda_oe,                    // Serial data drive enable
  input  wire logic        address_select_pin,        // Address LSB strap pin
  input  wire logic        test_mode,                 // Test mode select
  output logic             test_serial_in,            // Serial input to test block
  input  wire logic        dsp_clk,                   // Processor-side clock
  input  wire logic        host_transfer_instruction, // Transfer instruction pulse
  output logic [15:0]      dsp_addr,                  // Memory address of transfer
  output logic [23:0]      dsp_wdata,                 // Word written to memory
  output logic             dsp_wr,                    // Write strobe, one cycle
  output logic             dsp_rd,                    // Read strobe, one cycle
  input  wire logic [23:0] dsp_rdata                  // Word read from memory
);
  import i2cmem_pkg::*;

  // ============================================================
  // Line synchronisers and condition detection
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic asel_s1_ff, asel_s2_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // Two flops per line, a third for edges; 100 MHz oversamples 400 kHz
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_ff  <= 1'b1;
      scl_s2_ff  <= 1'b1;
      scl_s3_ff  <= 1'b1;
      sda_s1_ff  <= 1'b1;
      sda_s2_ff  <= 1'b1;
      sda_s3_ff  <= 1'b1;
      asel_s1_ff <= 1'b0;
      asel_s2_ff <= 1'b0;
    end else begin
      scl_s1_ff  <= scl_i;
      scl_s2_ff  <= scl_s1_ff;
      scl_s3_ff  <= scl_s2_ff;
      sda_s1_ff  <= sda_i;
      sda_s2_ff  <= sda_s1_ff;
      sda_s3_ff  <= sda_s2_ff;
      asel_s1_ff <= address_select_pin;
      asel_s2_ff <= asel_s1_ff;
    end
  end

  // Edges and bus conditions from synchronised samples
  assign scl_rise   = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall   = ~scl_s2_ff & scl_s3_ff;
  assign start_cond = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_cond  = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

  // Address pin doubles as test serial input
  assign test_serial_in = test_mode & asel_s2_ff;

  // ============================================================
  // Serial engine
  i2cmem_state_t state_ff;
  logic [2:0]    bit_cnt_ff;
  logic [7:0]    shift_ff;
  logic [7:0]    txsh_ff;
  logic          full_ff;
  logic [1:0]    byte_idx_ff;
  logic          rw_ff;
  logic          nack_ff;
  logic [15:0]   mem_addr_ff;
  logic [23:0]   word_ff;
  logic [23:0]   txword_ff;
  logic [23:0]   rdbuf_ff;
  logic [1:0]    wbyte_ff;
  logic          addr_match, byte_end, tx_next, word_last, wide;
  logic [1:0]    nbytes;
  logic [7:0]    tx_pick, tx_pick_buf;

  // Bytes per word follow the memory addressed
  assign wide        = ~mem_addr_ff[WIDE_SEL_BIT];
  assign nbytes      = wide ? BYTES_WIDE : BYTES_NARROW;
  assign word_last   = (wbyte_ff == nbytes - 2'h1);
  assign addr_match  = (shift_ff[7:1] == {SLV_ADDR_HI, asel_s2_ff});
  assign byte_end    = scl_fall & (state_ff == ST_RX) & full_ff;
  assign tx_next     = scl_fall & (state_ff == ST_MACK) & ~nack_ff;

  // Byte within a word, most significant first
  always_comb begin
    unique case (nbytes - 2'h1 - (tx_next ? (word_last ? 2'h0 : wbyte_ff + 2'h1)
                                          : 2'h0))
      2'h2: begin
        tx_pick     = txword_ff[23:16];
        tx_pick_buf = rdbuf_ff[23:16];
      end
      2'h1: begin
        tx_pick     = txword_ff[15:8];
        tx_pick_buf = rdbuf_ff[15:8];
      end
      default: begin
        tx_pick     = txword_ff[7:0];
        tx_pick_buf = rdbuf_ff[7:0];
      end
    endcase
  end

  // State, bit counting and shifting; START and STOP override all
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= BITCNT_RST;
      shift_ff    <= 8'h00;
      txsh_ff     <= 8'hFF;
      full_ff     <= 1'b0;
      byte_idx_ff <= IDX_DEV;
      rw_ff       <= 1'b0;
      nack_ff     <= 1'b0;
    end else if (start_cond) begin
      state_ff    <= ST_RX;
      bit_cnt_ff  <= BITCNT_RST;
      full_ff     <= 1'b0;
      byte_idx_ff <= IDX_DEV;
    end else if (stop_cond) begin
      state_ff    <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_IGNORE: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], sda_s2_ff};  // One bit per pulse
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            full_ff    <= (bit_cnt_ff == BITCNT_LAST);
          end else if (byte_end) begin
            full_ff <= 1'b0;
            if (byte_idx_ff == IDX_DEV) begin
              state_ff <= addr_match ? ST_ACK : ST_IGNORE;
              rw_ff    <= shift_ff[0];
            end else begin
              state_ff <= ST_ACK;                      // Every byte acked
            end
            if (byte_idx_ff != IDX_DATA) begin
              byte_idx_ff <= byte_idx_ff + 2'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= BITCNT_RST;
            if (rw_ff && byte_idx_ff == IDX_AHI) begin
              state_ff <= ST_TX;                       // Read direction
              txsh_ff  <= tx_pick_buf;
            end else begin
              state_ff <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == BITCNT_LAST) begin
              state_ff <= ST_MACK;                     // Release for master ack
            end else begin
              txsh_ff    <= {txsh_ff[6:0], 1'b1};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack_ff <= sda_s2_ff;
          end else if (scl_fall) begin
            bit_cnt_ff <= BITCNT_RST;
            if (nack_ff) begin
              state_ff <= ST_IGNORE;                   // Free the bus
            end else begin
              state_ff <= ST_TX;
              txsh_ff  <= word_last ? tx_pick_buf : tx_pick;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Word assembly, address stepping and transfer launch
  logic        go_ff, xfer_we_ff, wr_done, first_load;
  logic [15:0] xfer_addr_ff;
  logic [23:0] xfer_data_ff;
  assign wr_done    = byte_end & (byte_idx_ff == IDX_DATA) & word_last;
  assign first_load = scl_fall & (state_ff == ST_ACK) & rw_ff & (byte_idx_ff == IDX_AHI);

  // Memory address, word bytes, and one-cycle launch requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr_ff  <= ADDR_RST;
      word_ff      <= WORD_RST;
      txword_ff    <= WORD_RST;
      wbyte_ff     <= 2'h0;
      go_ff        <= 1'b0;
      xfer_we_ff   <= 1'b0;
      xfer_addr_ff <= ADDR_RST;
      xfer_data_ff <= WORD_RST;
    end else begin
      go_ff <= 1'b0;
      if (byte_end && byte_idx_ff == IDX_AHI) begin
        mem_addr_ff[15:8] <= shift_ff;
      end else if (byte_end && byte_idx_ff == IDX_ALO) begin
        mem_addr_ff[7:0] <= shift_ff;
        wbyte_ff         <= 2'h0;
        go_ff            <= 1'b1;                      // Prefetch first read word
        xfer_we_ff       <= 1'b0;
        xfer_addr_ff     <= {mem_addr_ff[15:8], shift_ff};
      end else if (byte_end && byte_idx_ff == IDX_DATA) begin
        word_ff <= {word_ff[15:0], shift_ff};
        if (word_last) begin
          wbyte_ff     <= 2'h0;
          mem_addr_ff  <= mem_addr_ff + 16'h0001;
          go_ff        <= 1'b1;
          xfer_we_ff   <= 1'b1;
          xfer_addr_ff <= mem_addr_ff;
          xfer_data_ff <= wide ? {word_ff[15:0], shift_ff} : {8'h00, word_ff[7:0], shift_ff};
        end else begin
          wbyte_ff <= wbyte_ff + 2'h1;
        end
      end else if (first_load) begin
        txword_ff    <= rdbuf_ff;
        wbyte_ff     <= 2'h0;
        go_ff        <= 1'b1;                          // Fetch the following word
        xfer_we_ff   <= 1'b0;
        xfer_addr_ff <= mem_addr_ff + 16'h0001;
      end else if (tx_next) begin
        if (word_last) begin
          txword_ff    <= rdbuf_ff;
          wbyte_ff     <= 2'h0;
          mem_addr_ff  <= mem_addr_ff + 16'h0001;
          go_ff        <= 1'b1;
          xfer_we_ff   <= 1'b0;
          xfer_addr_ff <= mem_addr_ff + 16'h0002;
        end else begin
          wbyte_ff <= wbyte_ff + 2'h1;
        end
      end
    end
  end

  // ============================================================
  // Serial data drive: only low, changed after SCL falls
  logic drive, sda_oe_ff;

  assign drive = (state_ff == ST_ACK) | ((state_ff == ST_TX) & ~txsh_ff[7]);

  // Registered drive, so no decode glitch reaches the pad
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_ff <= 1'b0;                               // Released from reset
    end else begin
      sda_oe_ff <= drive;
    end
  end

  assign sda_o  = 1'b0;                                // Open drain
  assign sda_oe = sda_oe_ff;

  // ============================================================
  // Clock crossing: toggle request out, toggle acknowledge back
  logic        req_tgl_ff, dack_tgl_ff;
  logic        ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic [23:0] drd_ff;
  // Request toggle and read return capture on the core side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_tgl_ff <= 1'b0;
      ack_s1_ff  <= 1'b0;
      ack_s2_ff  <= 1'b0;
      ack_s3_ff  <= 1'b0;
      rdbuf_ff   <= WORD_RST;
    end else begin
      ack_s1_ff <= dack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      if (go_ff && (req_tgl_ff == ack_s2_ff)) begin
        req_tgl_ff <= ~req_tgl_ff;                     // Busy: new word replaces old
      end
      if (ack_s2_ff != ack_s3_ff) begin
        rdbuf_ff <= drd_ff;                            // Held stable since toggle
      end
    end
  end

  logic req_s1_ff, req_s2_ff, seen_ff;
  logic pending;
  assign pending = (req_s2_ff != seen_ff);

  // Processor side: act only on the transfer instruction
  always_ff @(posedge dsp_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_ff   <= 1'b0;
      req_s2_ff   <= 1'b0;
      seen_ff     <= 1'b0;
      dack_tgl_ff <= 1'b0;
      drd_ff      <= WORD_RST;
      dsp_addr    <= ADDR_RST;
      dsp_wdata   <= WORD_RST;
      dsp_wr      <= 1'b0;
      dsp_rd      <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      dsp_wr    <= 1'b0;
      dsp_rd    <= 1'b0;
      if (pending && host_transfer_instruction) begin
        seen_ff     <= req_s2_ff;
        dack_tgl_ff <= ~dack_tgl_ff;
        dsp_addr    <= xfer_addr_ff;
        dsp_wdata   <= xfer_data_ff;
        dsp_wr      <= xfer_we_ff;
        dsp_rd      <= ~xfer_we_ff;
        drd_ff      <= dsp_rdata;
      end
    end
  end

  // ============================================================
  // Checks
  sequence s_ack_done;
    (state_ff == ST_ACK) ##1 (state_ff != ST_ACK);
  endsequence
  chk_idle_release: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_IDLE) ##1 (state_ff == ST_IDLE) |-> !sda_oe)
    else $error("SDA driven on idle bus");
  chk_start_seen: assert property (@(posedge clk) disable iff (!arst_n)
    start_cond |=> (state_ff == ST_RX) && (byte_idx_ff == IDX_DEV) && (bit_cnt_ff == 3'h0))
    else $error("START not taken");
  chk_stop_seen: assert property (@(posedge clk) disable iff (!arst_n)
    stop_cond && !start_cond |=> (state_ff == ST_IDLE) ##1 !sda_oe)
    else $error("STOP not taken");
  chk_drive_steady: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(drive) |-> $past(scl_fall) || $past(start_cond) || $past(stop_cond))
    else $error("SDA drive changed outside SCL low");
  chk_ack_low: assert property (@(posedge clk) disable iff (!arst_n)
    s_ack_done |-> sda_oe)
    else $error("Acknowledge not held to SCL fall");
  chk_byte_acked: assert property (@(posedge clk) disable iff (!arst_n)
    byte_end && (byte_idx_ff != IDX_DEV) && !start_cond && !stop_cond |=> (state_ff == ST_ACK) ##1 sda_oe)
    else $error("Received byte not acknowledged");
  chk_addr_miss: assert property (@(posedge clk) disable iff (!arst_n)
    byte_end && (byte_idx_ff == IDX_DEV) && !addr_match && !start_cond && !stop_cond
    |=> (state_ff == ST_IGNORE) [*2])
    else $error("Foreign address answered");
  chk_nack_free: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_MACK) && nack_ff && scl_fall && !start_cond && !stop_cond
    |=> (state_ff == ST_IGNORE) ##1 !sda_oe)
    else $error("Bus held after not-acknowledge");
  chk_word_step: assert property (@(posedge clk) disable iff (!arst_n)
    wr_done && !start_cond && !stop_cond |=> (mem_addr_ff == $past(mem_addr_ff) + 16'h0001) && go_ff)
    else $error("Address not stepped after word");
  chk_hti_only: assert property (@(posedge dsp_clk) disable iff (!arst_n)
    (dsp_wr || dsp_rd) |-> $past(host_transfer_instruction) && !(dsp_wr && dsp_rd))
    else $error("Transfer without instruction");

endmodule : i2cmem_slave

// *** i2cmem_master_model.sv ***
// ============================================================
// Bus master model for the two-wire serial port of the memory slave.
// Assumes the bench resolves the data line with a pull-up from all drivers.
`timescale 1ns/1ns
module i2cmem_master_model (
  input  wire logic clk,       // Core clock, used as time base
  output logic      scl,       // Serial clock drive
  output logic      sda_pull,  // High pulls the data line low
  input  wire logic sda_line   // Resolved data line level
);
  localparam int HALF = 125;   // Half bit period in cycles, 400 kHz
  localparam int QTR  = 62;    // Quarter bit period in cycles

  // Both lines released at rest
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // One bit per pulse, data moved only while clock low
  task automatic put_bit(input logic b, output logic seen);
    sda_pull = ~b;
    wait_clk(QTR);
    scl = 1'b1;
    wait_clk(QTR);
    seen = sda_line;
    wait_clk(HALF - QTR);
    scl = 1'b0;
    wait_clk(HALF - QTR);
  endtask : put_bit

  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    wait_clk(QTR);
    scl = 1'b1;
    wait_clk(QTR);
    sda_pull = 1'b1;
    wait_clk(QTR);
    scl = 1'b0;
    wait_clk(QTR);
  endtask : start

  // Stop: data rises while clock high, then bus rests
  task automatic stop();
    sda_pull = 1'b1;
    wait_clk(QTR);
    scl = 1'b1;
    wait_clk(QTR);
    sda_pull = 1'b0;
    wait_clk(HALF);
  endtask : stop

  // Byte out, then line released for the extra acknowledge pulse
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Byte in; acknowledge pulled low, or withheld on the last byte
  task automatic recv_byte(input logic give_ack, output logic [7:0] b,
                           output logic slot);
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(~give_ack, slot);
  endtask : recv_byte
endmodule : i2cmem_master_model

// *** testbench.sv ***
// ============================================================
// Self-checking bench for the serial memory access slave.
// Assumes the design package, the slave and the master model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  logic        clk, arst_n, dsp_clk, host_transfer_instruction;
  logic        test_mode, address_select_pin, scl, sda_pull, sda_line;
  logic        sda_o, sda_oe, test_serial_in, dsp_wr, dsp_rd, scl_q, oe_q;
  logic [15:0] dsp_addr;
  logic [23:0] dsp_wdata, dsp_rdata;
  logic [7:0]  rd_n;
  logic [15:0] wa[$], ra[$];
  logic [23:0] wd[$];
  int          fail_count, samples_checked;

  // Open-drain data line with pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
  assign dsp_rdata = {8'h5A, 8'hC3, rd_n};

  i2cmem_slave i_i2cmem_slave (.clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .test_mode(test_mode), .test_serial_in(test_serial_in), .dsp_clk(dsp_clk),
    .host_transfer_instruction(host_transfer_instruction), .dsp_addr(dsp_addr),
    .dsp_wdata(dsp_wdata), .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata));
  i2cmem_master_model i_i2cmem_master_model (.clk(clk), .scl(scl), .sda_pull(sda_pull),
    .sda_line(sda_line));

  // Clocks: core 10 ns, processor side 64 ns at its own phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    dsp_clk = 1'b0;
    #7;
    forever #32 dsp_clk = ~dsp_clk;
  end

  // Memory side: logs strobes, read word tagged by request count
  always @(posedge dsp_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_n <= 8'h00;
    end else begin
      if (dsp_rd) begin
        rd_n <= rd_n + 8'h01;
        ra.push_back(dsp_addr);
      end
      if (dsp_wr) begin
        wa.push_back(dsp_addr);
        wd.push_back(dsp_wdata);
      end
    end
  end

  // Slave data drive must not move while the clock is high
  always @(posedge clk) begin
    scl_q <= scl;
    oe_q  <= sda_oe;
    if (arst_n === 1'b1 && scl === 1'b1 && scl_q === 1'b1) `CHK(sda_oe, oe_q)
  end

  // ============================================================
  // Shared tasks
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_q(input bit rd, input int n);
    int k;
    k = 0;
    while ((rd ? ra.size() : wa.size()) < n && k < 400) begin
      @(negedge dsp_clk);
      k++;
    end
    if (k >= 400) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_q

  task automatic tx(input logic [7:0] b, input logic exp);
    logic a;
    i_i2cmem_master_model.send_byte(b, a);
    `CHK(a, exp)
  endtask : tx

  // ============================================================
  // Scenarios
  task automatic scen_test_mode();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      test_mode = i[1];
      address_select_pin = i[0];
      repeat (6) @(negedge clk);
      `CHK(test_serial_in, i[1] & i[0])
    end
    address_select_pin = 1'b0;
    test_mode = 1'b0;
    repeat (10) @(negedge clk);
  endtask : scen_test_mode

  task automatic scen_write_wide();
    i_i2cmem_master_model.start();
    tx(8'h38, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h10, 1'b1);
    for (int i = 1; i <= 7; i++) tx(8'(8'h11 * i), 1'b1);
    i_i2cmem_master_model.stop();
    wait_q(1'b0, 2);
    repeat (100) @(negedge dsp_clk);
    `CHK(wa.size(), 2)
    `CHK(wa[0], 16'h0010)
    `CHK(wa[1], 16'h0011)
    `CHK(wd[0], 24'h112233)
    `CHK(wd[1], 24'h445566)
    wa.delete();
    wd.delete();
  endtask : scen_write_wide

  task automatic scen_narrow_held();
    @(negedge dsp_clk);
    host_transfer_instruction = 1'b0;
    @(negedge clk);
    address_select_pin = 1'b1;
    repeat (10) @(negedge clk);
    i_i2cmem_master_model.start();
    tx(8'h3A, 1'b1);
    tx(8'h0F, 1'b1);
    tx(8'hF9, 1'b1);
    tx(8'hBE, 1'b1);
    tx(8'hEF, 1'b1);
    i_i2cmem_master_model.stop();
    repeat (50) @(negedge dsp_clk);
    `CHK(wa.size(), 0)
    host_transfer_instruction = 1'b1;
    wait_q(1'b0, 1);
    repeat (20) @(negedge dsp_clk);
    `CHK(wa.size(), 1)
    `CHK(wa[0], 16'h0FF9)
    `CHK(wd[0], 24'h00BEEF)
    wa.delete();
    wd.delete();
  endtask : scen_narrow_held

  task automatic scen_wrong_addr();
    i_i2cmem_master_model.start();
    tx(8'h38, 1'b0);
    tx(8'h00, 1'b0);
    i_i2cmem_master_model.stop();
    `CHK(sda_oe, 1'b0)
    `CHK(sda_o, 1'b0)
    repeat (50) @(negedge dsp_clk);
    `CHK(wa.size(), 0)
    @(negedge clk);
    address_select_pin = 1'b0;
    repeat (10) @(negedge clk);
  endtask : scen_wrong_addr

  task automatic scen_read(input logic [15:0] addr, input int words, input int nb);
    logic [7:0]  b, base;
    logic [23:0] word;
    logic        slot, last;
    base = rd_n;
    ra.delete();
    i_i2cmem_master_model.start();
    tx(8'h38, 1'b1);
    tx(addr[15:8], 1'b1);
    tx(addr[7:0], 1'b1);
    i_i2cmem_master_model.start();
    tx(8'h39, 1'b1);
    for (int w = 0; w < words; w++) begin
      word = {8'h5A, 8'hC3, 8'(base + w)};
      for (int j = 0; j < nb; j++) begin
        last = (w == words - 1) && (j == nb - 1);
        i_i2cmem_master_model.recv_byte(~last, b, slot);
        `CHK(b, word[8 * (nb - 1 - j) +: 8])
      end
    end
    `CHK(slot, 1'b1)
    i_i2cmem_master_model.stop();
    wait_q(1'b1, words);
    for (int w = 0; w < words; w++) `CHK(ra[w], 16'(addr + w))
  endtask : scen_read

  // Timeout guard
  initial begin
    #950000;
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    host_transfer_instruction = 1'b1;
    test_mode = 1'b0;
    address_select_pin = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk);
    `CHK(sda_oe, 1'b0)
    `CHK(dsp_wr, 1'b0)
    `CHK(dsp_addr, 16'h0000)
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    scen_test_mode();
    scen_write_wide();
    scen_narrow_held();
    scen_wrong_addr();
    scen_read(16'h0020, 2, 3);
    scen_read(16'h0805, 2, 2);
    give_verdict();
  end
endmodule : testbench
